// [core/pcsi_core.sv]
// Program counter, return stack and indirect data access of the core.
// Assumes the decoder gives one operation per valid cycle and data
// memory returns read data one cycle after its read strobe.
//
// Summary of operation
// - Program counter is 13 bits; low byte readable and writable.
// - Software sets upper counter bits only through the high latch, never directly.
// - Any reset clears the whole program counter.
// - Writing the low byte loads upper five bits from latch at once.
// - Call or jump takes top two bits from latch bits 4 and 3.
// - Return stack holds eight entries of 13 bits.
// - Stack and its pointer are invisible to software.
// - Call pushes the program counter plus one; interrupt branch pushes the program counter.
// - Return, literal return and interrupt return pop the stack.
// - Push and pop leave the high latch unchanged.
// - Stack is circular; ninth push overwrites the oldest entry.
// - No overflow or underflow status exists.
// - Indirect port accesses the location the file pointer selects.
// - Indirect read pointing at the indirect port returns zero.
// - Indirect write pointing at the indirect port stores nothing.
// - Indirect address is 9 bits: file pointer plus bank bit.
// - Taken interrupt with global enable pushes and jumps to vector.
`timescale 1ns/10ps
module pcsi_core #(
  parameter int DEPTH = pcsi_pkg::STK_DEP
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        op_valid_i,
  input  wire logic [3:0]  op_code_i,
  input  wire logic [10:0] op_target_i,
  input  wire logic [7:0]  op_data_i,
  input  wire logic        int_req_i,
  output logic             int_taken_o,
  output logic      [12:0] pc_o,
  output logic      [8:0]  dm_addr_o,
  output logic             dm_re_o,
  output logic             dm_we_o,
  output logic      [7:0]  dm_wdata_o,
  input  wire logic [7:0]  dm_rdata_i
);

  // ==========================================================
  // Declarations
  pcsi_pkg::pcsi_state_e st_q, st_d;

  logic [12:0] pc_q, stk_top, push_val;
  logic [7:0]  latch_q, fptr_q, adr_q, wdat_q, rdat_q;
  logic [2:0]  sp_q, sp_d, stk_raddr;
  logic        bank_q, gie_q, we_q, sel0_q;
  logic        exec, wr, is_ind, self_ref, low_wr, latch_wr;
  logic        op_go, int_go, op_x, is_ret, do_push, do_pop;

  // ==========================================================
  // Bus request capture and slave sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      pcsi_pkg::PCSI_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          st_d = pcsi_pkg::PCSI_EXEC;
        end
      end
      pcsi_pkg::PCSI_EXEC:  st_d = pcsi_pkg::PCSI_FETCH;
      pcsi_pkg::PCSI_FETCH: st_d = pcsi_pkg::PCSI_ACK;
      pcsi_pkg::PCSI_ACK:   st_d = pcsi_pkg::PCSI_IDLE;
      default:              st_d = pcsi_pkg::PCSI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= pcsi_pkg::PCSI_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adr_q  <= pcsi_pkg::BYTE_RST;
      we_q   <= 1'b0;
      sel0_q <= 1'b0;
      wdat_q <= pcsi_pkg::BYTE_RST;
    end else if (st_q == pcsi_pkg::PCSI_IDLE && wb_cyc_i && wb_stb_i) begin
      adr_q  <= wb_adr_i;
      we_q   <= wb_we_i;
      sel0_q <= wb_sel_i[0];
      wdat_q <= wb_dat_i[7:0];
    end
  end

  assign exec     = (st_q == pcsi_pkg::PCSI_EXEC);
  assign wr       = exec && we_q && sel0_q;
  assign is_ind   = (adr_q == pcsi_pkg::OFF_INDIRECT);
  assign low_wr   = wr && (adr_q == pcsi_pkg::OFF_PC_LOW);
  assign latch_wr = wr && (adr_q == pcsi_pkg::OFF_HI_LATCH);
  assign self_ref = (fptr_q[6:0] == pcsi_pkg::INDIRECT_LOC);

  // ==========================================================
  // Indirect data access
  // Port redirects to data memory
  assign dm_re_o    = exec && is_ind && !we_q && !self_ref;
  assign dm_we_o    = exec && is_ind && we_q && sel0_q && !self_ref;
  assign dm_wdata_o = wdat_q;
  assign dm_addr_o  = {bank_q, fptr_q};

  // ==========================================================
  // Read data and answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= pcsi_pkg::BYTE_RST;
    end else if (st_q == pcsi_pkg::PCSI_FETCH) begin
      case (adr_q)
        pcsi_pkg::OFF_INDIRECT:
          rdat_q <= (self_ref || we_q) ? pcsi_pkg::BYTE_RST : dm_rdata_i;
        pcsi_pkg::OFF_PC_LOW:   rdat_q <= pc_q[7:0];
        pcsi_pkg::OFF_STATUS:   rdat_q <= {bank_q, 7'h00};
        pcsi_pkg::OFF_FILE_PTR: rdat_q <= fptr_q;
        pcsi_pkg::OFF_HI_LATCH: rdat_q <= latch_q;
        pcsi_pkg::OFF_CONTROL:  rdat_q <= {7'h00, gie_q};
        default:                rdat_q <= pcsi_pkg::BYTE_RST;
      endcase
    end
  end

  assign wb_ack_o = (st_q == pcsi_pkg::PCSI_ACK);
  assign wb_dat_o = {24'h000000, rdat_q};

  // ==========================================================
  // Software registers
  // Bus is the only writer, except the enable, which vectoring and interrupt return also write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= pcsi_pkg::BYTE_RST;
    end else if (latch_wr) begin
      latch_q <= wdat_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fptr_q <= pcsi_pkg::BYTE_RST;
    end else if (wr && adr_q == pcsi_pkg::OFF_FILE_PTR) begin
      fptr_q <= wdat_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= 1'b0;
    end else if (wr && adr_q == pcsi_pkg::OFF_STATUS) begin
      bank_q <= wdat_q[pcsi_pkg::STATUS_BANK_POS];
    end
  end

  // Vectoring clears enable, interrupt return sets it again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_q <= 1'b0;
    end else if (op_x && op_code_i == pcsi_pkg::OP_RETINT) begin
      gie_q <= 1'b1;
    end else if (int_go) begin
      gie_q <= 1'b0;
    end else if (wr && adr_q == pcsi_pkg::OFF_CONTROL) begin
      gie_q <= wdat_q[pcsi_pkg::CTRL_GIE_POS];
    end
  end

  // ==========================================================
  // Operation decode
  assign op_go  = op_valid_i && !low_wr;
  assign int_go = op_go && int_req_i && gie_q;
  assign op_x   = op_go && !int_go;
  assign is_ret = (op_code_i == pcsi_pkg::OP_RETURN) ||
                  (op_code_i == pcsi_pkg::OP_RETLIT) ||
                  (op_code_i == pcsi_pkg::OP_RETINT);
  assign do_push  = int_go || (op_x && op_code_i == pcsi_pkg::OP_CALL);
  assign do_pop   = op_x && is_ret;
  assign push_val = int_go ? pc_q : pc_q + 13'h0001;
  assign int_taken_o = int_go;

  // ==========================================================
  // Program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= pcsi_pkg::PC_RST;
    end else if (low_wr) begin
      pc_q <= {latch_q[4:0], wdat_q};
    end else if (int_go) begin
      pc_q <= pcsi_pkg::INT_VECTOR;
    end else if (op_x) begin
      case (op_code_i)
        pcsi_pkg::OP_CALL, pcsi_pkg::OP_JUMP:
          pc_q <= {latch_q[4:3], op_target_i};
        pcsi_pkg::OP_RETURN, pcsi_pkg::OP_RETLIT, pcsi_pkg::OP_RETINT:
          pc_q <= stk_top;
        pcsi_pkg::OP_WRLOW:  pc_q <= {latch_q[4:0], op_data_i};
        pcsi_pkg::OP_STEP:   pc_q <= pc_q + 13'h0001;
        default:             pc_q <= pc_q;
      endcase
    end
  end

  assign pc_o = pc_q;

  // ==========================================================
  // Return stack
  // Pointer wraps freely
  always_comb begin
    sp_d = sp_q;
    if (do_push) begin
      sp_d = sp_q + 3'h1;
    end else if (do_pop) begin
      sp_d = sp_q - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= 3'h0;
    end else begin
      sp_q <= sp_d;
    end
  end

  assign stk_raddr = sp_d - 3'h1;

  pcsi_stack_mem #(
    .DEPTH (DEPTH),
    .WIDTH (pcsi_pkg::PC_W),
    .AW    (pcsi_pkg::STK_AW)
  ) pcsi_stack_mem_inst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (do_push),
    .waddr_i (sp_q),
    .wdata_i (push_val),
    .raddr_i (stk_raddr),
    .rdata_o (stk_top)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_pc;
    disable iff (1'b0) rst_i |=> (pc_q == pcsi_pkg::PC_RST);
  endproperty
  a_rst_pc: assert property (p_rst_pc)
    else $error("PC not cleared by reset");
  property p_low_wr;
    op_x && op_code_i == pcsi_pkg::OP_WRLOW |=>
      pc_q == {$past(latch_q[4:0]), $past(op_data_i)};
  endproperty
  a_low_wr: assert property (p_low_wr)
    else $error("Low-byte write did not load all bits");
  property p_call_hi;
    op_x && op_code_i == pcsi_pkg::OP_CALL |=>
      pc_q[12:11] == $past(latch_q[4:3]) && pc_q[10:0] == $past(op_target_i);
  endproperty
  a_call_hi: assert property (p_call_hi)
    else $error("Call target bits wrong");
  property p_push;
    do_push |=> stk_top == $past(push_val) && sp_q == $past(sp_q) + 3'h1;
  endproperty
  a_push: assert property (p_push)
    else $error("Push did not store counter");
  property p_pop;
    do_pop |=> pc_q == $past(stk_top) && sp_q == $past(sp_q) - 3'h1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("Pop did not restore counter");
  property p_latch_keep;
    (do_push || do_pop) && !latch_wr |=> $stable(latch_q);
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("Stack action changed high latch");
  sequence s_self_rd;
    exec && is_ind && !we_q && self_ref;
  endsequence
  property p_self_rd;
    s_self_rd |-> ##2 (wb_ack_o && wb_dat_o == 32'h00000000);
  endproperty
  a_self_rd: assert property (p_self_rd)
    else $error("Self-pointing read not zero");
  property p_self_wr;
    exec && is_ind && self_ref |-> !dm_we_o && !dm_re_o;
  endproperty
  a_self_wr: assert property (p_self_wr)
    else $error("Self-pointing access reached memory");
  property p_ind_addr;
    wr && adr_q == pcsi_pkg::OFF_FILE_PTR |=>
      dm_addr_o[7:0] == $past(wdat_q) && dm_addr_o[8] == $past(bank_q);
  endproperty
  a_ind_addr: assert property (p_ind_addr)
    else $error("Indirect address not formed from pointer");
  sequence s_vector;
    int_go ##1 pc_q == pcsi_pkg::INT_VECTOR;
  endsequence
  property p_vector;
    int_go |-> s_vector;
  endproperty
  a_vector: assert property (p_vector)
    else $error("Interrupt did not reach vector");

endmodule : pcsi_core

// [core/pcsi_stack_mem.sv]
// Circular return stack storage with a registered read port.
// Assumes the caller drives the read address of the next stack top.
`timescale 1ns/10ps
module pcsi_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13,
  parameter int AW    = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // ==========================================================
  // Read register, bypass on same-slot write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (we_i && (waddr_i == raddr_i)) begin
      rdata_q <= wdata_i;
    end else begin
      rdata_q <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule : pcsi_stack_mem

// [inc/pcsi_pkg.sv]
// Package for the program counter, return stack and indirect access block.
// Assumes a single core clock and a classic Wishbone register slave.
package pcsi_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W    = 13;
  localparam int STK_DEP = 8;
  localparam int STK_AW  = 3;
  localparam int TGT_W   = 11;
  localparam int DA_W    = 9;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_INDIRECT = 8'h00;
  localparam logic [7:0] OFF_PC_LOW   = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_FILE_PTR = 8'h0C;
  localparam logic [7:0] OFF_HI_LATCH = 8'h10;
  localparam logic [7:0] OFF_CONTROL  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int STATUS_BANK_POS = 7;
  localparam int CTRL_GIE_POS    = 0;

  // ==========================================================
  // Reset values and fixed addresses
  localparam logic [12:0] PC_RST      = 13'h0000;
  localparam logic [12:0] INT_VECTOR  = 13'h0004;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [6:0]  INDIRECT_LOC = 7'h00;

  // ==========================================================
  // Decoder operation codes
  localparam logic [3:0] OP_STEP   = 4'h0;
  localparam logic [3:0] OP_CALL   = 4'h1;
  localparam logic [3:0] OP_JUMP   = 4'h2;
  localparam logic [3:0] OP_RETURN = 4'h3;
  localparam logic [3:0] OP_RETLIT = 4'h4;
  localparam logic [3:0] OP_RETINT = 4'h5;
  localparam logic [3:0] OP_WRLOW  = 4'h6;

  // ==========================================================
  // Bus slave states
  typedef enum logic [3:0] {
    PCSI_IDLE  = 4'h1,
    PCSI_EXEC  = 4'h2,
    PCSI_FETCH = 4'h4,
    PCSI_ACK   = 4'h8
  } pcsi_state_e;

endpackage : pcsi_pkg

// [verif/pcsi_dmem_model.sv]
// Data memory partner of the core: 512 bytes, registered read port.
// Assumes strobes and address come from the core on the same clock.
`timescale 1ns/10ps
module pcsi_dmem_model (
  input  wire logic       clk_i,
  input  wire logic [8:0] dm_addr_i,
  input  wire logic       dm_re_i,
  input  wire logic       dm_we_i,
  input  wire logic [7:0] dm_wdata_i,
  output logic      [7:0] dm_rdata_o
);
  // ==========================================================
  // Storage
  logic [7:0] mem [512];

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'hC3;
    end
    dm_rdata_o = 8'h00;
  end

  // Read data only valid the cycle after the strobe
  always @(posedge clk_i) begin
    if (dm_we_i) begin
      mem[dm_addr_i] <= dm_wdata_i;
    end
    if (dm_re_i) begin
      dm_rdata_o <= mem[dm_addr_i];
    end else begin
      dm_rdata_o <= ~dm_rdata_o;
    end
  end
endmodule : pcsi_dmem_model

// [verif/tb_program_counter_stack_indirect.sv]
// Self-checking bench for the program counter and indirect access core.
// Assumes the core's Wishbone slave, decoder port and the memory model.
`timescale 1ns/10ps
module tb_program_counter_stack_indirect;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        op_valid_i = 1'b0;
  logic [3:0]  op_code_i = 4'h0;
  logic [10:0] op_target_i = 11'h000;
  logic [7:0]  op_data_i = 8'h00;
  logic        int_req_i = 1'b0;
  logic        int_taken_o;
  logic [12:0] pc_o;
  logic [8:0]  dm_addr_o;
  logic        dm_re_o;
  logic        dm_we_o;
  logic [7:0]  dm_wdata_o;
  logic [7:0]  dm_rdata_i;
  int          miscompares = 0;
  int          checked = 0;
  int          we_cnt = 0;
  logic [31:0] rd;
  logic [12:0] pv [10];

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (dm_we_o === 1'b1) begin
      we_cnt <= we_cnt + 1;
    end
  end

  pcsi_core pcsi_core_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_target_i(op_target_i),
    .op_data_i(op_data_i), .int_req_i(int_req_i),
    .int_taken_o(int_taken_o), .pc_o(pc_o), .dm_addr_o(dm_addr_o),
    .dm_re_o(dm_re_o), .dm_we_o(dm_we_o), .dm_wdata_o(dm_wdata_o),
    .dm_rdata_i(dm_rdata_i));

  pcsi_dmem_model pcsi_dmem_model_inst (.clk_i(clk_i),
    .dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o), .dm_we_i(dm_we_o),
    .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i));

  // ==========================================================
  // Shared tasks
  task automatic final_report;
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, wb_ack_o,
               1'b1);
      final_report();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask : wb

  task automatic do_op(input logic [3:0] code, input logic [10:0] tgt,
                       input logic [7:0] dat, input logic irq,
                       input logic taken);
    @(posedge clk_i);
    op_valid_i  <= 1'b1;
    op_code_i   <= code;
    op_target_i <= tgt;
    op_data_i   <= dat;
    int_req_i   <= irq;
    #1;
    chk(32'(int_taken_o), 32'(taken));
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    int_req_i  <= 1'b0;
    #1;
  endtask : do_op

  // ==========================================================
  // Scenarios
  task automatic s_pc_load;
    wb(1'b1, pcsi_pkg::OFF_HI_LATCH, 8'h03);
    wb(1'b1, pcsi_pkg::OFF_PC_LOW, 8'hFF);
    chk(32'(pc_o), 32'h000003FF);
    do_op(pcsi_pkg::OP_STEP, 11'h000, 8'h00, 1'b0, 1'b0);
    wb(1'b0, pcsi_pkg::OFF_HI_LATCH, 8'h00);
    chk(rd, 32'h00000003);
    wb(1'b0, pcsi_pkg::OFF_PC_LOW, 8'h00);
    chk(rd, 32'h00000000);
    wb(1'b1, pcsi_pkg::OFF_HI_LATCH, 8'h15);
    wb(1'b1, pcsi_pkg::OFF_PC_LOW, 8'hA5);
    chk(32'(pc_o), 32'h000015A5);
    wb(1'b0, pcsi_pkg::OFF_PC_LOW, 8'h00);
    chk(rd, 32'h000000A5);
    do_op(pcsi_pkg::OP_WRLOW, 11'h000, 8'h33, 1'b0, 1'b0);
    chk(32'(pc_o), 32'h00001533);
  endtask : s_pc_load

  task automatic s_call;
    do_op(pcsi_pkg::OP_CALL, 11'h7FF, 8'h00, 1'b0, 1'b0);
    chk(32'(pc_o), 32'h000017FF);
    do_op(pcsi_pkg::OP_JUMP, 11'h123, 8'h00, 1'b0, 1'b0);
    chk(32'(pc_o), 32'h00001123);
    do_op(pcsi_pkg::OP_RETURN, 11'h000, 8'h00, 1'b0, 1'b0);
    chk(32'(pc_o), 32'h00001534);
    wb(1'b0, pcsi_pkg::OFF_HI_LATCH, 8'h00);
    chk(rd, 32'h00000015);
  endtask : s_call

  task automatic s_wrap;
    logic [12:0] cur;
    logic [3:0]  rc;
    wb(1'b1, pcsi_pkg::OFF_HI_LATCH, 8'h00);
    wb(1'b1, pcsi_pkg::OFF_PC_LOW, 8'h10);
    cur = 13'h0010;
    for (int k = 1; k <= 9; k++) begin
      pv[k] = cur + 13'h0001;
      do_op(pcsi_pkg::OP_CALL, 11'(k * 16), 8'h00, 1'b0, 1'b0);
      cur = 13'(k * 16);
      chk(32'(pc_o), 32'(cur));
    end
    wb(1'b0, pcsi_pkg::OFF_STATUS, 8'h00);
    chk(rd, 32'h00000000);
    for (int j = 0; j < 8; j++) begin
      rc = (j % 3 == 0) ? pcsi_pkg::OP_RETURN :
           (j % 3 == 1) ? pcsi_pkg::OP_RETLIT : pcsi_pkg::OP_RETINT;
      do_op(rc, 11'h000, 8'h00, 1'b0, 1'b0);
      chk(32'(pc_o), 32'(pv[9 - j]));
    end
  endtask : s_wrap

  task automatic s_int;
    wb(1'b1, pcsi_pkg::OFF_PC_LOW, 8'h40);
    wb(1'b1, pcsi_pkg::OFF_CONTROL, 8'h00);
    do_op(pcsi_pkg::OP_STEP, 11'h000, 8'h00, 1'b1, 1'b0);
    chk(32'(pc_o), 32'h00000041);
    wb(1'b1, pcsi_pkg::OFF_CONTROL, 8'h01);
    do_op(pcsi_pkg::OP_STEP, 11'h000, 8'h00, 1'b1, 1'b1);
    chk(32'(pc_o), 32'h00000004);
    wb(1'b0, pcsi_pkg::OFF_CONTROL, 8'h00);
    chk(rd, 32'h00000000);
    do_op(pcsi_pkg::OP_RETINT, 11'h000, 8'h00, 1'b0, 1'b0);
    chk(32'(pc_o), 32'h00000041);
  endtask : s_int

  task automatic s_ind;
    int n;
    wb(1'b1, pcsi_pkg::OFF_STATUS, 8'h80);
    wb(1'b0, pcsi_pkg::OFF_STATUS, 8'h00);
    chk(rd, 32'h00000080);
    wb(1'b1, pcsi_pkg::OFF_FILE_PTR, 8'h20);
    chk(32'(dm_addr_o), 32'h00000120);
    n = we_cnt;
    wb(1'b1, pcsi_pkg::OFF_INDIRECT, 8'h5A);
    chk(32'(we_cnt), 32'(n + 1));
    wb(1'b0, pcsi_pkg::OFF_INDIRECT, 8'h00);
    chk(rd, 32'h0000005A);
    wb(1'b1, pcsi_pkg::OFF_STATUS, 8'h00);
    chk(32'(dm_addr_o), 32'h00000020);
    wb(1'b0, pcsi_pkg::OFF_INDIRECT, 8'h00);
    chk(rd, 32'h000000E3);
    wb(1'b1, pcsi_pkg::OFF_FILE_PTR, 8'h80);
    wb(1'b0, pcsi_pkg::OFF_INDIRECT, 8'h00);
    chk(rd, 32'h00000000);
    n = we_cnt;
    wb(1'b1, pcsi_pkg::OFF_INDIRECT, 8'h77);
    chk(32'(we_cnt), 32'(n));
    wb(1'b0, 8'h18, 8'h00);
    chk(rd, 32'h00000000);
  endtask : s_ind

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(32'(pc_o), 32'h00000000);
    s_pc_load();
    s_call();
    s_wrap();
    s_int();
    s_ind();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(32'(pc_o), 32'h00000000);
    final_report();
  end
endmodule : tb_program_counter_stack_indirect
